//--- dcsb_pkg.sv
// constants and types for the dual capture memory with sync logic
package dcsb_pkg;
	localparam int          DEPTH      = 4096;
	localparam int          AW         = 12;
	localparam int          CW         = 13;
	localparam int          HOST_AW    = 10;
	localparam int          HOST_DW    = 16;
	localparam int          PAGE_W     = 4;
	localparam int          PAGE_MEM_B = 3;
	localparam int          HOST_IQ_B  = 0;
	localparam int          NSYNC      = 4;
	localparam logic [CW-1:0] DEPTH_C  = 13'h1000;
	localparam logic [11:0] CNT_MAX    = 12'hFFF;

	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} dcsb_cplx_t;

	typedef enum logic [2:0] {
		SRC_TXREF = 3'h0, SRC_FB = 3'h1, SRC_ERR = 3'h2, SRC_PROBE = 3'h3, SRC_ODERR = 3'h4
	} dcsb_src_t;

	typedef enum logic [1:0] {MODE_STD = 2'h0, MODE_SMART = 2'h1, MODE_PLAY = 2'h2} dcsb_mode_t;

	typedef enum logic [2:0] {
		SYN_A = 3'h0, SYN_B = 3'h1, SYN_C = 3'h2, SYN_D = 3'h3, SYN_TIMER = 3'h4, SYN_SW = 3'h5
	} dcsb_sync_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_WAIT_SYNC = 3'h1, ST_DELAY = 3'h2, ST_WAIT_TRIG = 3'h3,
		ST_STORE = 3'h4, ST_PLAY = 3'h5, ST_DONE = 3'h6
	} dcsb_state_t;

	typedef struct packed {
		dcsb_mode_t  mode;
		dcsb_src_t   src;
		dcsb_sync_t  sync_sel;
		logic [15:0] delay;
		logic [12:0] depth;
		logic [16:0] mag_thr;
		logic [31:0] pow_thr;
		logic [11:0] cnt_thr;
		logic        trig_both;
	} dcsb_cfg_t;
endpackage

//--- dcsb_capture.sv
// dual capture memory, sync event logic and asynchronous host read port
`timescale 1ns/10ps
`default_nettype none
module dcsb_capture (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire dcsb_pkg::dcsb_cplx_t          tx_ref,
	input  wire dcsb_pkg::dcsb_cplx_t          fb_out,
	input  wire dcsb_pkg::dcsb_cplx_t          err_out,
	input  wire dcsb_pkg::dcsb_cplx_t          orthogonal_decomp_error,
	input  wire logic [31:0]                   probe_bus,
	input  wire logic                          sample_valid,
	input  wire dcsb_pkg::dcsb_cfg_t           cfg_a,
	input  wire dcsb_pkg::dcsb_cfg_t           cfg_b,
	input  wire logic [1:0]                    arm,
	input  wire logic                          sync_a,
	input  wire logic                          sync_b,
	input  wire logic                          sync_c,
	input  wire logic                          sync_d,
	input  wire logic                          sw_sync,
	input  wire logic [31:0]                   timer_period,
	input  wire logic [3:0]                    host_page,
	input  wire logic [9:0]                    host_address,
	input  wire logic [15:0]                   host_data_in,
	input  wire logic                          chip_select_n,
	input  wire logic                          read_strobe_n,
	input  wire logic                          write_strobe_n,
	input  wire logic                          output_enable_n,
	output logic [15:0]                        host_data_out,
	output logic                               host_data_oe,
	output logic [1:0]                         capture_done,
	output logic                               init_done,
	output logic                               sync_out,
	output dcsb_pkg::dcsb_cplx_t               play_data,
	output logic                               play_valid
);
	import dcsb_pkg::*;

	function automatic logic [16:0] mag_est(input dcsb_cplx_t x);
		logic [16:0] a;
		logic [16:0] b;
		a = x.re[15] ? 17'(-x.re) : 17'(x.re);
		b = x.im[15] ? 17'(-x.im) : 17'(x.im);
		// max plus half min: no multiplier, error under 12 percent
		mag_est = (a > b) ? 17'(a + (b >> 1)) : 17'(b + (a >> 1));
	endfunction

	function automatic logic [31:0] pow_of(input dcsb_cplx_t x);
		pow_of = 32'(x.re * x.re) + 32'(x.im * x.im);
	endfunction

	function automatic dcsb_cplx_t pick(input dcsb_src_t s, input logic first);
		dcsb_cplx_t p;
		p = tx_ref;
		case (s)
			SRC_FB:    p = fb_out;
			SRC_ERR:   p = err_out;
			SRC_PROBE: p = first ? {probe_bus[31:16], 16'h0000} : {probe_bus[15:0], 16'h0000};
			SRC_ODERR: p = first ? orthogonal_decomp_error : tx_ref;
			default:   p = tx_ref;
		endcase
		pick = p;
	endfunction

	function automatic logic [CW-1:0] lim_of(input logic [12:0] d);
		lim_of = (d == 13'h0000 || d > DEPTH_C) ? DEPTH_C : d;
	endfunction

	// sync inputs arrive from other clock domains or pins
	logic [NSYNC-1:0] sy1_q, sy2_q, sy3_q;
	logic [NSYNC-1:0] sy_evt;
	logic [31:0]      tmr_q, tmr_d;
	logic             tmr_evt;
	logic [5:0]       evt;
	logic             init_q, init_d, sout_q, sout_d;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sy1_q <= 4'h0;
			sy2_q <= 4'h0;
			sy3_q <= 4'h0;
		end else begin
			sy1_q <= {sync_d, sync_c, sync_b, sync_a};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	always_comb begin
		sy_evt  = sy2_q & ~sy3_q;
		tmr_evt = (timer_period != 32'h0000_0000) && (tmr_q == timer_period - 32'h0000_0001);
		tmr_d   = (timer_period == 32'h0000_0000 || tmr_evt) ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
		evt     = {sw_sync, tmr_evt, sy_evt};
		init_d  = init_q | sy_evt[0];
		sout_d  = evt[cfg_a.sync_sel];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tmr_q  <= 32'h0000_0000;
			init_q <= 1'b0;
			sout_q <= 1'b0;
		end else begin
			tmr_q  <= tmr_d;
			init_q <= init_d;
			sout_q <= sout_d;
		end
	end

	// capture memories, real and imaginary halves apart so host writes need no merge
	logic [15:0]   mem_re [0:1][0:DEPTH-1];
	logic [15:0]   mem_im [0:1][0:DEPTH-1];
	logic [1:0]    we_re, we_im;
	logic [AW-1:0] wa [0:1];
	logic [15:0]   wd_re [0:1];
	logic [15:0]   wd_im [0:1];

	dcsb_state_t   st_q [0:1], st_d [0:1];
	logic [CW-1:0] ad_q [0:1], ad_d [0:1];
	logic [15:0]   dl_q [0:1], dl_d [0:1];
	logic [11:0]   mc_q [0:1], mc_d [0:1];
	logic [11:0]   pc_q [0:1], pc_d [0:1];
	logic [1:0]    done_q, done_d;
	dcsb_cplx_t    smp [0:1];
	dcsb_cfg_t     cfg [0:1];
	logic [11:0]   mc_n, pc_n;
	logic          hit;

	// host strobes are asynchronous: two flops, then edge detect on the second
	logic [3:0]    hs1_q, hs2_q, hs3_q;
	logic [13:0]   ha1_q, ha2_q;
	logic [15:0]   hd1_q, hd2_q;
	logic          h_rd, h_wr, h_mem;
	logic [AW-1:0] h_ent;
	logic [15:0]   hrd_q, hrd_d;
	logic          hoe_q, hoe_d;
	dcsb_cplx_t    pd_q, pd_d;
	logic          pv_q, pv_d;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hs1_q <= 4'hF;
			hs2_q <= 4'hF;
			hs3_q <= 4'hF;
			ha1_q <= 14'h0000;
			ha2_q <= 14'h0000;
			hd1_q <= 16'h0000;
			hd2_q <= 16'h0000;
		end else begin
			hs1_q <= {output_enable_n, write_strobe_n, read_strobe_n, chip_select_n};
			hs2_q <= hs1_q;
			hs3_q <= hs2_q;
			ha1_q <= {host_page, host_address};
			ha2_q <= ha1_q;
			hd1_q <= host_data_in;
			hd2_q <= hd1_q;
		end
	end

	always_comb begin
		h_rd  = ~hs2_q[0] & ~hs2_q[1] & (hs3_q[1] | hs3_q[0]);
		h_wr  = ~hs2_q[0] & ~hs2_q[2] & (hs3_q[2] | hs3_q[0]);
		h_mem = ha2_q[HOST_AW + PAGE_MEM_B];
		h_ent = {ha2_q[HOST_AW+2:HOST_AW], ha2_q[HOST_AW-1:1]};
		hrd_d = hrd_q;
		if (h_rd)
			hrd_d = ha2_q[HOST_IQ_B] ? mem_im[h_mem][h_ent] : mem_re[h_mem][h_ent];
		hoe_d = ~hs2_q[0] & ~hs2_q[3];
	end

	always_comb begin
		cfg[0] = cfg_a;
		cfg[1] = cfg_b;
		pd_d   = pd_q;
		pv_d   = 1'b0;
		mc_n   = 12'h000;
		pc_n   = 12'h000;
		hit    = 1'b0;
		done_d = done_q;
		for (int m = 0; m < 2; m++) begin
			smp[m]   = pick(cfg[m].src, m == 0);
			st_d[m]  = st_q[m];
			ad_d[m]  = ad_q[m];
			dl_d[m]  = dl_q[m];
			mc_d[m]  = mc_q[m];
			pc_d[m]  = pc_q[m];
			we_re[m] = 1'b0;
			we_im[m] = 1'b0;
			wa[m]    = ad_q[m][AW-1:0];
			wd_re[m] = smp[m].re;
			wd_im[m] = smp[m].im;
			case (st_q[m])
				ST_IDLE, ST_DONE: begin
					// host may load memories only while they are quiet
					if (h_wr && h_mem == m[0]) begin
						we_re[m] = ~ha2_q[HOST_IQ_B];
						we_im[m] = ha2_q[HOST_IQ_B];
						wa[m]    = h_ent;
						wd_re[m] = hd2_q;
						wd_im[m] = hd2_q;
					end
				end
				ST_WAIT_SYNC: begin
					if (evt[cfg[m].sync_sel]) begin
						dl_d[m] = cfg[m].delay;
						st_d[m] = ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (dl_q[m] == 16'h0000)
						st_d[m] = (cfg[m].mode == MODE_PLAY && m == 0) ? ST_PLAY : ST_STORE;
					else
						dl_d[m] = dl_q[m] - 16'h0001;
				end
				ST_WAIT_TRIG: begin
					if (sample_valid) begin
						mc_n = mc_q[m] + {11'h000, (mag_est(smp[m]) > cfg[m].mag_thr) && mc_q[m] != CNT_MAX};
						pc_n = pc_q[m] + {11'h000, (pow_of(smp[m]) > cfg[m].pow_thr) && pc_q[m] != CNT_MAX};
						mc_d[m] = mc_n;
						pc_d[m] = pc_n;
						hit = cfg[m].trig_both ? (mc_n >= cfg[m].cnt_thr && pc_n >= cfg[m].cnt_thr)
						                       : (mc_n >= cfg[m].cnt_thr || pc_n >= cfg[m].cnt_thr);
						if (hit)
							st_d[m] = ST_STORE;
					end
				end
				ST_STORE: begin
					if (sample_valid) begin
						we_re[m] = 1'b1;
						we_im[m] = 1'b1;
						ad_d[m]  = ad_q[m] + 13'h0001;
						if (ad_q[m] == (cfg[m].mode == MODE_SMART ? lim_of(cfg[m].depth) : DEPTH_C) - 13'h0001) begin
							st_d[m]   = ST_DONE;
							done_d[m] = 1'b1;
						end
					end
				end
				ST_PLAY: begin
					if (sample_valid && m == 0) begin
						pd_d    = {mem_re[0][ad_q[0][AW-1:0]], mem_im[0][ad_q[0][AW-1:0]]};
						pv_d    = 1'b1;
						ad_d[m] = ad_q[m] + 13'h0001;
						if (ad_q[m] == lim_of(cfg[m].depth) - 13'h0001) begin
							st_d[m]   = ST_DONE;
							done_d[m] = 1'b1;
						end
					end
				end
				default: st_d[m] = ST_IDLE;
			endcase
			// arming restarts from any state, but only once initialised
			if (arm[m] && init_q) begin
				done_d[m] = 1'b0;
				ad_d[m]   = 13'h0000;
				mc_d[m]   = 12'h000;
				pc_d[m]   = 12'h000;
				st_d[m]   = (cfg[m].mode == MODE_SMART) ? ST_WAIT_TRIG : ST_WAIT_SYNC;
			end
		end
	end

	always_ff @(posedge clock) begin
		for (int m = 0; m < 2; m++) begin
			if (we_re[m])
				mem_re[m][wa[m]] <= wd_re[m];
			if (we_im[m])
				mem_im[m][wa[m]] <= wd_im[m];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int m = 0; m < 2; m++) begin
				st_q[m] <= ST_IDLE;
				ad_q[m] <= 13'h0000;
				dl_q[m] <= 16'h0000;
				mc_q[m] <= 12'h000;
				pc_q[m] <= 12'h000;
			end
			done_q <= 2'h0;
			hrd_q  <= 16'h0000;
			hoe_q  <= 1'b0;
			pd_q   <= 32'h0000_0000;
			pv_q   <= 1'b0;
		end else begin
			for (int m = 0; m < 2; m++) begin
				st_q[m] <= st_d[m];
				ad_q[m] <= ad_d[m];
				dl_q[m] <= dl_d[m];
				mc_q[m] <= mc_d[m];
				pc_q[m] <= pc_d[m];
			end
			done_q <= done_d;
			hrd_q  <= hrd_d;
			hoe_q  <= hoe_d;
			pd_q   <= pd_d;
			pv_q   <= pv_d;
		end
	end

	assign host_data_out = hrd_q;
	assign host_data_oe  = hoe_q;
	assign capture_done  = done_q;
	assign init_done     = init_q;
	assign sync_out      = sout_q;
	assign play_data     = pd_q;
	assign play_valid    = pv_q;

	property p_addr_step;
		@(posedge clock) disable iff (rst)
		(st_q[1] == ST_STORE && sample_valid && !arm[1] && st_d[1] == ST_STORE) |=> ad_q[1] == $past(ad_q[1]) + 13'h0001;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("capture address did not step");

	property p_done_hold;
		@(posedge clock) disable iff (rst)
		(st_q[0] == ST_DONE && !arm[0]) |=> (st_q[0] == ST_DONE && capture_done[0]);
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("finished capture left done");

	property p_no_store_done;
		@(posedge clock) disable iff (rst)
		(st_q[1] == ST_DONE && !h_wr) |-> (we_re[1] == 1'b0 && we_im[1] == 1'b0);
	endproperty
	a_no_store_done: assert property (p_no_store_done) else $error("write after capture end");

	property p_std_len;
		@(posedge clock) disable iff (rst)
		$rose(capture_done[1]) && cfg_b.mode == MODE_STD |-> ad_q[1] == DEPTH_C;
	endproperty
	a_std_len: assert property (p_std_len) else $error("standard capture length wrong");

	property p_init;
		@(posedge clock) disable iff (rst)
		(sy2_q[0] && !sy3_q[0]) |=> init_done ##1 init_done;
	endproperty
	a_init: assert property (p_init) else $error("primary sync did not initialise");

	property p_sync_out;
		@(posedge clock) disable iff (rst)
		sync_out |-> $past(evt[cfg_a.sync_sel]);
	endproperty
	a_sync_out: assert property (p_sync_out) else $error("debug sync without event");

	property p_sync_start;
		@(posedge clock) disable iff (rst)
		(st_q[0] == ST_WAIT_SYNC && evt[cfg_a.sync_sel] && !arm[0]) |=> st_q[0] == ST_DELAY;
	endproperty
	a_sync_start: assert property (p_sync_start) else $error("sync did not start delay");

	property p_play;
		@(posedge clock) disable iff (rst)
		play_valid |-> $past(st_q[0]) == ST_PLAY && $past(sample_valid);
	endproperty
	a_play: assert property (p_play) else $error("playout outside play state");

	property p_trig;
		@(posedge clock) disable iff (rst)
		(st_q[0] == ST_WAIT_TRIG ##1 st_q[0] == ST_STORE) |-> (mc_q[0] >= cfg_a.cnt_thr || pc_q[0] >= cfg_a.cnt_thr);
	endproperty
	a_trig: assert property (p_trig) else $error("smart trigger without count");

	property p_host_oe;
		@(posedge clock) disable iff (rst)
		##1 host_data_oe == $past(!hs2_q[0] && !hs2_q[3]);
	endproperty
	a_host_oe: assert property (p_host_oe) else $error("host drive enable wrong");
endmodule
`default_nettype wire

//--- dcsb_host_model.sv
// host processor model fetching capture entries over the asynchronous host bus
`timescale 1ns/10ps
`default_nettype none
module dcsb_host_model (
	input  wire logic        clock,
	input  wire logic        req,
	input  wire logic [12:0] entry,
	input  wire logic        imag,
	input  wire logic [15:0] host_data_out,
	output logic [3:0]       host_page,
	output logic [9:0]       host_address,
	output logic [15:0]      host_data_in,
	output logic             chip_select_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             output_enable_n,
	output logic             done,
	output logic [15:0]      rdata
);
	initial begin
		{chip_select_n, read_strobe_n, write_strobe_n, output_enable_n} = 4'hF;
		host_page = 4'h0;
		host_address = 10'h000;
		host_data_in = 16'h0000;
		done = 1'b0;
		rdata = 16'h0000;
	end
	// nobody drives the data pins towards the device, so they wander every cycle
	always @(posedge clock) host_data_in <= ~host_data_in;
	always begin
		@(posedge clock);
		if (req) begin
			#1 host_page = entry[12:9];
			host_address = {entry[8:0], imag};
			repeat (3) @(posedge clock);
			#1 {chip_select_n, read_strobe_n, output_enable_n} = 3'h0;
			// strobe held five edges: the answer lands three edges after the fall
			repeat (5) @(posedge clock);
			rdata = host_data_out;
			#1 {chip_select_n, read_strobe_n, output_enable_n} = 3'h7;
			host_address = ~host_address;
			done = 1'b1;
			@(posedge clock);
			#1 done = 1'b0;
			repeat (2) @(posedge clock);
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the dual capture memory with sync logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import dcsb_pkg::*;
	logic        clock, rst, sample_valid, sync_a, sync_b, sync_c, sync_d, sw_sync, req, imag;
	dcsb_cplx_t  tx_ref, fb_out, err_out, od_err, play_data;
	dcsb_cfg_t   cfg_a, cfg_b;
	logic [31:0] probe_bus;
	logic [1:0]  arm, capture_done;
	logic [12:0] entry;
	logic [9:0]  host_address;
	logic [3:0]  host_page;
	logic [15:0] host_data_in, host_data_out, rdata, cnt;
	logic        cs_n, rd_n, wr_n, oe_n, host_data_oe, init_done, sync_out, play_valid, done;
	logic [31:0] exp_q[$];
	logic [31:0] pq[$];
	logic [31:0] tmr_p;
	int          err_total, checks, cycles, n, i, e;

	dcsb_capture DUT (.clock(clock), .rst(rst), .tx_ref(tx_ref), .fb_out(fb_out), .err_out(err_out),
		.orthogonal_decomp_error(od_err), .probe_bus(probe_bus), .sample_valid(sample_valid),
		.cfg_a(cfg_a), .cfg_b(cfg_b), .arm(arm), .sync_a(sync_a), .sync_b(sync_b), .sync_c(sync_c),
		.sync_d(sync_d), .sw_sync(sw_sync), .timer_period(tmr_p), .host_page(host_page),
		.host_address(host_address), .host_data_in(host_data_in), .chip_select_n(cs_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .output_enable_n(oe_n),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe), .capture_done(capture_done),
		.init_done(init_done), .sync_out(sync_out), .play_data(play_data), .play_valid(play_valid));
	dcsb_host_model host (.clock(clock), .req(req), .entry(entry), .imag(imag),
		.host_data_out(host_data_out), .host_page(host_page), .host_address(host_address),
		.host_data_in(host_data_in), .chip_select_n(cs_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .output_enable_n(oe_n), .done(done), .rdata(rdata));

	always #2.5 clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] expect_v);
		checks++;
		if (seen !== expect_v) begin
			err_total++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, expect_v);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// drives n valid samples with random gaps; sample k carries the running count
	task automatic feed(input int num);
		int k;
		k = 0;
		while (k < num) begin
			@(posedge clock);
			#1 sample_valid = ($urandom % 4) != 0;
			fb_out = {cnt, cnt ^ 16'hA5A5};
			probe_bus = {~cnt, cnt ^ 16'h5A5A};
			tx_ref = {cnt ^ 16'hFFFF, cnt};
			err_out = {cnt, 16'h1234};
			od_err = {16'h4321, cnt};
			if (sample_valid) begin
				cnt++;
				k++;
			end
		end
		@(posedge clock);
		#1 sample_valid = 1'b0;
	endtask

	task automatic read(input logic mem, input int idx, input logic half, input logic [15:0] val);
		exp_q.push_back({16'h0000, val});
		entry = {mem, idx[11:0]};
		imag = half;
		// request held until the answer, so the model cannot miss it between accesses
		req = 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clock);
			n++;
		end
		#1 req = 1'b0;
		@(posedge clock);
		#1 check(n < 40, 1);
	endtask

	// playout samples are launched on the rising edge, so look on the falling one
	always @(negedge clock) begin
		if (play_valid === 1'b1)
			check(play_data, pq.pop_front());
	end

	// the answer shows while the device still drives the pins
	always @(posedge clock) begin
		if (done === 1'b1) begin
			check({16'h0000, rdata}, exp_q.pop_front());
			check(host_data_oe, 1);
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			end_of_test;
		end
	end

	initial begin
		{clock, sample_valid, sync_a, sync_b, sync_c, sync_d, sw_sync, req, imag} = 9'h0;
		tx_ref = 32'h0000_0000;
		fb_out = 32'h0000_0000;
		err_out = 32'h0000_0000;
		od_err = 32'h0000_0000;
		probe_bus = 32'h0000_0000;
		tmr_p = 32'h0000_0000;
		arm = 2'h0;
		entry = 13'h0000;
		cnt = 16'h0000;
		err_total = 0;
		checks = 0;
		cycles = 0;
		rst = 1'b1;
		cfg_a = '{mode: MODE_STD, src: SRC_FB, sync_sel: SYN_A, delay: 16'h0014, default: '0};
		cfg_b = '{mode: MODE_STD, src: SRC_PROBE, sync_sel: SYN_A, delay: 16'h0003, default: '0};
		void'($urandom(32'h361F685C));
		repeat (3) @(posedge clock);
		#1 rst = 1'b0;
		check(init_done, 0);
		sync_a = 1'b1;
		repeat (3) @(posedge clock);
		#1 sync_a = 1'b0;
		n = 0;
		while (sync_out !== 1'b1 && n < 8) begin
			@(posedge clock);
			#1 n++;
		end
		check(sync_out, 1);
		check(init_done, 1);
		@(posedge clock);
		#1 check(sync_out, 0);
		cfg_a.sync_sel = SYN_SW;
		arm = 2'h3;
		@(posedge clock);
		#1 arm = 2'h0;
		sw_sync = 1'b1;
		@(posedge clock);
		#1 sw_sync = 1'b0;
		check(sync_out, 1);
		sync_a = 1'b1;
		repeat (3) @(posedge clock);
		#1 sync_a = 1'b0;
		repeat (40) @(posedge clock);
		feed(4096);
		check(capture_done, 2'h3);
		feed(8);
		check(capture_done, 2'h3);
		for (i = 0; i < 6; i++) begin
			e = (i == 0) ? 0 : (i == 1) ? 4095 : int'($urandom % 4096);
			read(1'b0, e, 1'b0, e[15:0]);
			read(1'b0, e, 1'b1, e[15:0] ^ 16'hA5A5);
			read(1'b1, e, 1'b0, e[15:0] ^ 16'h5A5A);
			read(1'b1, e, 1'b1, 16'h0000);
		end
		// playout of the first capture on memory A, smart capture on memory B
		for (i = 0; i < 4; i++)
			pq.push_back({16'(i), 16'(i) ^ 16'hA5A5});
		cfg_a.mode = MODE_PLAY;
		cfg_a.delay = 16'h0000;
		cfg_a.depth = 13'h0004;
		cfg_a.sync_sel = SYN_SW;
		cfg_b = '{mode: MODE_SMART, src: SRC_FB, sync_sel: SYN_A, depth: 13'h0003, mag_thr: 17'h00000,
			pow_thr: 32'hFFFF_FFFF, cnt_thr: 12'h002, default: '0};
		arm = 2'h3;
		@(posedge clock);
		#1 arm = 2'h0;
		sw_sync = 1'b1;
		@(posedge clock);
		#1 sw_sync = 1'b0;
		e = int'(cnt);
		feed(5);
		repeat (2) @(posedge clock);
		#1 check(capture_done, 2'h3);
		check(pq.size(), 0);
		read(1'b1, 0, 1'b0, 16'(e + 2));
		read(1'b1, 2, 1'b1, 16'(e + 4) ^ 16'hA5A5);
		// each remaining pin sync, seen through the debug output
		for (i = 1; i < 4; i++) begin
			cfg_a.sync_sel = dcsb_sync_t'(i);
			{sync_d, sync_c, sync_b} = 3'(1 << (i - 1));
			repeat (3) @(posedge clock);
			#1 {sync_d, sync_c, sync_b} = 3'h0;
			n = 0;
			while (sync_out !== 1'b1 && n < 8) begin
				@(posedge clock);
				#1 n++;
			end
			check(sync_out, 1);
		end
		cfg_a.sync_sel = SYN_TIMER;
		tmr_p = 32'h0000_000A;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			#1 n += sync_out;
		end
		tmr_p = 32'h0000_0000;
		check(n, 4);
		repeat (6) @(posedge clock);
		#1 check(host_data_oe, 0);
		check(exp_q.size(), 0);
		end_of_test;
	end
endmodule
`default_nettype wire
